// ### logic/ptrq_core.sv
// Functional notes
// - Queue events with buttons, wheel, X, Y.
// - Interrupt while queue nonempty and enabled.
// - Queue depth sixteen events.
// - Mode input selects relative or absolute.
// - Writing one loads next event.
// - Load on empty queue changes nothing.
// - Count register reports queued events.
// - Mouse mode X, Y signed deltas.
// - Touch mode positions clamped to 0..7FFF.
// - X right positive, Y down positive.
// - Wheel is signed delta, down positive.
// - Button bits, bit0 first, set pressed.
// - Unmask register enables interrupt, resets zero.
// - Limit register reports queue capacity.
//
// Decided for this implementation: the APB register port.
`include "ptrq_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module ptrq_core (
   input  wire logic               pclk,       // APB clock
   input  wire logic               presetn,    // Async reset, active low
   input  wire logic               clk_en,     // Freezes all state when low
   input  wire logic               abs_mode,   // 1 touchscreen, 0 mouse (strap)
   input  wire logic               psel,       // APB select
   input  wire logic               penable,    // APB enable
   input  wire logic               pwrite,     // APB direction
   input  wire logic [11:0]        paddr,      // APB byte address
   input  wire logic [31:0]        pwdata,     // APB write data
   output logic      [31:0]        prdata,     // APB read data
   output logic                    pready,     // APB ready
   output logic                    pslverr,    // APB error, unmapped address or write to a read-only register
   input  wire logic               ev_valid,   // Event strobe, same clock
   input  wire ptrq_pkg::ptrq_event_s ev_data, // Event content
   output logic                    irq         // Level interrupt
);
   localparam int DEPTH = `PTRQ_DEPTH;

   typedef struct packed {
      ptrq_pkg::ptrq_event_s [DEPTH-1:0] mem;
      logic [3:0]  wr_ptr;
      logic [3:0]  rd_ptr;
      logic [4:0]  count;
      ptrq_pkg::ptrq_event_s readout;
      logic        unmask;
      logic [1:0]  status;
      logic [1:0]  evmask;
      logic        mode;
      logic        mode_ok;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        irq;
   } ptrq_state_s;

   ptrq_state_s s_q;
   ptrq_state_s s_d;

   // Straps ride through two flops before use
   logic abs_m1_q;
   logic abs_m2_q;

   ////////////////////////////////////////////////////////////////////////////
   // No reset here: the pair keeps tracking the strap through reset, so the
   // mode caught at the first edge after release is the strap, not a default
   always_ff @(posedge pclk) begin
      if (clk_en) begin
         abs_m1_q <= abs_mode;
         abs_m2_q <= abs_m1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] clamp_abs(input logic [31:0] v);
      logic [31:0] r;
      r = v;
      if (v[31])
         r = 32'h00000000;
      else if (v > `PTRQ_ABS_MAX)
         r = `PTRQ_ABS_MAX;
      return r;
   endfunction

   logic                  acc;
   logic                  wr_acc;
   logic                  rd_acc;
   logic                  do_push;
   logic                  do_pop;
   logic                  full;
   ptrq_pkg::ptrq_event_s ev_in;

   always_comb begin
      s_d    = s_q;
      acc    = psel && penable && !s_q.pready;
      wr_acc = acc && pwrite;
      rd_acc = acc && !pwrite;
      full   = (s_q.count == 5'(DEPTH));
      ev_in  = ev_data;
      // Touch mode clamps to the absolute range; mouse passes signed deltas
      // clamp absolute coords
      if (s_q.mode) begin
         ev_in.xpos = clamp_abs(ev_data.xpos);
         ev_in.ypos = clamp_abs(ev_data.ypos);
      end
      do_push = ev_valid && !full;
      do_pop  = wr_acc && (paddr == `PTRQ_OFS_LOAD) && (pwdata == 32'h00000001)
                && (s_q.count != 5'h00);

      // Mode caught once after reset release
      if (!s_q.mode_ok) begin
         s_d.mode    = abs_m2_q;
         s_d.mode_ok = 1'b1;
      end

      if (do_push) begin
         s_d.mem[s_q.wr_ptr] = ev_in;
         s_d.wr_ptr = s_q.wr_ptr + 4'h1;
      end
      if (do_pop) begin
         s_d.readout = s_q.mem[s_q.rd_ptr];
         s_d.rd_ptr  = s_q.rd_ptr + 4'h1;
      end
      s_d.count = s_q.count + 5'(do_push) - 5'(do_pop);

      // Sticky events; set wins over a same-cycle clear
      if (wr_acc && (paddr == `PTRQ_OFS_STATUS))
         s_d.status = s_q.status & ~pwdata[1:0];
      if (s_d.count != 5'h00)
         s_d.status[`PTRQ_ST_NOTEMPTY] = 1'b1;
      if (ev_valid && full)
         s_d.status[`PTRQ_ST_OVERFLOW] = 1'b1;

      if (wr_acc && (paddr == `PTRQ_OFS_UNMASK))
         s_d.unmask = pwdata[0];
      if (wr_acc && (paddr == `PTRQ_OFS_EVMASK))
         s_d.evmask = pwdata[1:0];

      // One wait state in the access phase, then ready drops for the next transfer
      s_d.pready  = acc;
      s_d.pslverr = 1'b0;
      s_d.prdata  = 32'h00000000;
      if (rd_acc) begin
         if (paddr == `PTRQ_OFS_ID)
            s_d.prdata = s_q.mode ? `PTRQ_ID_TOUCH : `PTRQ_ID_MOUSE;
         else if (paddr == `PTRQ_OFS_COUNT)
            s_d.prdata = {27'h0000000, s_q.count};
         else if (paddr == `PTRQ_OFS_XPOS)
            s_d.prdata = s_q.readout.xpos;
         else if (paddr == `PTRQ_OFS_YPOS)
            s_d.prdata = s_q.readout.ypos;
         else if (paddr == `PTRQ_OFS_WHEEL)
            s_d.prdata = s_q.readout.wheel;
         else if (paddr == `PTRQ_OFS_BUTTONS)
            s_d.prdata = s_q.readout.buttons;
         else if (paddr == `PTRQ_OFS_UNMASK)
            s_d.prdata = {31'h00000000, s_q.unmask};
         else if (paddr == `PTRQ_OFS_LIMIT)
            s_d.prdata = 32'(DEPTH);
         else if (paddr == `PTRQ_OFS_STATUS)
            s_d.prdata = {30'h00000000, s_q.status};
         else if (paddr == `PTRQ_OFS_EVMASK)
            s_d.prdata = {30'h00000000, s_q.evmask};
         else if (paddr != `PTRQ_OFS_LOAD)
            s_d.pslverr = 1'b1;
      end else if (wr_acc) begin
         if (paddr != `PTRQ_OFS_LOAD && paddr != `PTRQ_OFS_UNMASK &&
             paddr != `PTRQ_OFS_STATUS && paddr != `PTRQ_OFS_EVMASK)
            s_d.pslverr = 1'b1;
      end

      s_d.irq = (s_d.unmask && (s_d.count != 5'h00)) ||
                ((s_d.status & s_d.evmask) != 2'b00);
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q      <= '0;
         s_q.mode <= `PTRQ_ABS_DEFAULT;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   assign prdata  = s_q.prdata;
   assign pready  = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign irq     = s_q.irq;
endmodule
`default_nettype wire

// ### shared/ptrq_cfg.svh
`ifndef PTRQ_CFG_SVH
`define PTRQ_CFG_SVH
// Register byte offsets
`define PTRQ_OFS_ID        12'h000
`define PTRQ_OFS_LOAD      12'h004
`define PTRQ_OFS_COUNT     12'h008
`define PTRQ_OFS_XPOS      12'h00C
`define PTRQ_OFS_YPOS      12'h010
`define PTRQ_OFS_WHEEL     12'h014
`define PTRQ_OFS_BUTTONS   12'h018
`define PTRQ_OFS_UNMASK    12'h01C
`define PTRQ_OFS_LIMIT     12'h020
`define PTRQ_OFS_STATUS    12'h024
`define PTRQ_OFS_EVMASK    12'h028
// Identity codes are arbitrary neutral values
`define PTRQ_ID_MOUSE      32'h5A5A0001
`define PTRQ_ID_TOUCH      32'h5A5A0002
`define PTRQ_DEPTH         16
`define PTRQ_ABS_DEFAULT   1'b1
`define PTRQ_ABS_MAX       32'h00007FFF
// Status bit positions
`define PTRQ_ST_NOTEMPTY   0
`define PTRQ_ST_OVERFLOW   1
`define PTRQ_RST_WORD      32'h00000000
`endif

// ### shared/ptrq_pkg.sv
`default_nettype none
package ptrq_pkg;
   typedef struct packed {
      logic [31:0] buttons;
      logic [31:0] wheel;
      logic [31:0] ypos;
      logic [31:0] xpos;
   } ptrq_event_s;
endpackage
`default_nettype wire

// ### testbench/ptrq_core_monitor.sv
`timescale 1ns/1ns
`default_nettype none
`include "ptrq_cfg.svh"
module ptrq_core_monitor (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        abs_mode,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire rd_ok = pready && psel && !pwrite;
   ////////////////////////////////////////////////////////////
   property p_one_wait; psel && penable && !pready |=> pready; endproperty
   a_one_wait: assert property (p_one_wait) else $error("late ready");
   property p_ready_one; pready |=> !pready; endproperty
   a_ready_one: assert property (p_ready_one) else $error("ready held");
   property p_ready_cause; pready |-> $past(psel && penable); endproperty
   a_ready_cause: assert property (p_ready_cause) else $error("stray ready");
   property p_err_ready; pslverr |-> pready; endproperty
   a_err_ready: assert property (p_err_ready) else $error("lone error");
   property p_idle_zero; !rd_ok |-> prdata == 32'h00000000; endproperty
   a_idle_zero: assert property (p_idle_zero) else $error("data off read");
   property p_limit; rd_ok && paddr == `PTRQ_OFS_LIMIT |-> prdata == 32'h00000010; endproperty
   a_limit: assert property (p_limit) else $error("bad capacity");
   property p_ident; rd_ok && paddr == `PTRQ_OFS_ID
      |-> prdata == (abs_mode ? `PTRQ_ID_TOUCH : `PTRQ_ID_MOUSE); endproperty
   a_ident: assert property (p_ident) else $error("bad identity");
   property p_count_max; rd_ok && paddr == `PTRQ_OFS_COUNT |-> prdata <= 32'h00000010; endproperty
   a_count_max: assert property (p_count_max) else $error("count too big");
   property p_touch; rd_ok && abs_mode && (paddr == `PTRQ_OFS_XPOS || paddr == `PTRQ_OFS_YPOS)
      |-> prdata <= `PTRQ_ABS_MAX; endproperty
   a_touch: assert property (p_touch) else $error("position range");
endmodule
bind ptrq_core ptrq_core_monitor u_mon (.*);
`default_nettype wire

// ### testbench/ptrq_pointer_model.sv
`timescale 1ns/1ns
`default_nettype none
module ptrq_pointer_model (
   input  wire logic                 pclk,     // Shared clock
   output logic                      ev_valid, // Event strobe
   output var ptrq_pkg::ptrq_event_s ev_data   // Event content
);
   initial begin
      ev_valid = 1'b0;
      ev_data = '0;
   end
   task automatic send(input ptrq_pkg::ptrq_event_s e);
      @(posedge pclk);
      ev_valid <= 1'b1;
      ev_data <= e;
      @(posedge pclk);
      ev_valid <= 1'b0;
      // Stale content must not look valid
      ev_data <= ~e;
   endtask
endmodule
`default_nettype wire

// ### testbench/tb_ptrq_core.sv
`timescale 1ns/1ns
`default_nettype none
`include "ptrq_cfg.svh"
`define TB_CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin bad_count++; \
   $display("ERROR %s exp %h got %h", n, e, s); end end
module tb_ptrq_core;
   logic pclk = 1'b0, presetn = 1'b0, abs_mode = 1'b1, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, pready, pslverr, irq, ev_valid, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata, rd;
   ptrq_pkg::ptrq_event_s ev_data;
   int bad_count = 0, total_checks = 0;
   always #5 pclk = ~pclk;
   ptrq_core dut (.clk_en(1'b1), .*);
   ptrq_pointer_model pm (.pclk(pclk), .ev_valid(ev_valid), .ev_data(ev_data));
   ////////////////////////////////////////////////////////////
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h00000000);
      `TB_CHK($sformatf("reg %h", a), e, rd)
   endtask
   task automatic irqchk(input logic e);
      repeat (2) @(posedge pclk);
      #1 `TB_CHK("irq", e, irq)
   endtask
   task automatic rst;
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (5) @(posedge pclk);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // A few hundred cycles at most, so this only trips on a hang
   initial begin
      #200000;
      bad_count++;
      complete_run;
   end
   ////////////////////////////////////////////////////////////
   initial begin
      rst;
      chk(`PTRQ_OFS_COUNT, 32'h00000000);
      chk(`PTRQ_OFS_UNMASK, 32'h00000000);
      chk(`PTRQ_OFS_LIMIT, 32'h00000010);
      xfer(1'b0, 12'hFFC, 32'h00000000);
      `TB_CHK("slverr", 1'b1, err)
      $display("test reset done");
      pm.send({32'h00000005, 32'hFFFFFFFE, 32'hFFFFFFFB, 32'h00009000});
      pm.send({32'h00000002, 32'h00000003, 32'h00000456, 32'h00000123});
      chk(`PTRQ_OFS_COUNT, 32'h00000002);
      irqchk(1'b0);
      xfer(1'b1, `PTRQ_OFS_UNMASK, 32'h00000001);
      irqchk(1'b1);
      xfer(1'b1, `PTRQ_OFS_LOAD, 32'h00000002);
      chk(`PTRQ_OFS_COUNT, 32'h00000002);
      xfer(1'b1, `PTRQ_OFS_LOAD, 32'h00000001);
      chk(`PTRQ_OFS_XPOS, 32'h00007FFF);
      chk(`PTRQ_OFS_YPOS, 32'h00000000);
      chk(`PTRQ_OFS_WHEEL, 32'hFFFFFFFE);
      chk(`PTRQ_OFS_BUTTONS, 32'h00000005);
      xfer(1'b1, `PTRQ_OFS_LOAD, 32'h00000001);
      chk(`PTRQ_OFS_YPOS, 32'h00000456);
      irqchk(1'b0);
      xfer(1'b1, `PTRQ_OFS_LOAD, 32'h00000001);
      chk(`PTRQ_OFS_XPOS, 32'h00000123);
      $display("test load done");
      for (int i = 1; i < 18; i++) pm.send({96'h0, i[31:0]});
      chk(`PTRQ_OFS_COUNT, 32'h00000010);
      chk(`PTRQ_OFS_STATUS, 32'h00000003);
      xfer(1'b1, `PTRQ_OFS_UNMASK, 32'h00000000);
      xfer(1'b1, `PTRQ_OFS_EVMASK, 32'h00000002);
      irqchk(1'b1);
      xfer(1'b1, `PTRQ_OFS_STATUS, 32'h00000002);
      irqchk(1'b0);
      xfer(1'b1, `PTRQ_OFS_LOAD, 32'h00000001);
      chk(`PTRQ_OFS_XPOS, 32'h00000001);
      $display("test overflow done");
      abs_mode <= 1'b0;
      rst;
      chk(`PTRQ_OFS_ID, `PTRQ_ID_MOUSE);
      pm.send({32'h00000000, 32'h00000001, 32'h00000004, 32'hFFFFFFFD});
      xfer(1'b1, `PTRQ_OFS_LOAD, 32'h00000001);
      chk(`PTRQ_OFS_XPOS, 32'hFFFFFFFD);
      $display("test mouse done");
      complete_run;
   end
endmodule
`default_nettype wire
